//--- pertb_monitor.sv
// Bus and interrupt assertions for the period timer.
`timescale 1ns/1ns
`default_nettype none
module pertb_monitor (
	input wire logic clock, // Core clock.
	input wire logic nrst, // Reset, active low.
	input wire logic s_axi_awvalid, // Write address valid.
	input wire logic s_axi_awready, // Write address ready.
	input wire logic s_axi_wvalid, // Write data valid.
	input wire logic s_axi_wready, // Write data ready.
	input wire logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [11:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	input wire logic s_axi_arready, // Read address ready.
	input wire logic [31:0] s_axi_rdata, // Read data.
	input wire logic [1:0] s_axi_rresp, // Read response.
	input wire logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic irq // Interrupt.
);
	logic [9:0] ra_r;
	logic [9:0] ra_nxt;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// --------
	// Index of the read under way.
	// --------
	always_comb
	begin
		ra_nxt = ra_r;
		if (s_axi_arvalid && s_axi_arready)
			ra_nxt = s_axi_araddr[11:2];
	end
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			ra_r <= '0;
		else
			ra_r <= ra_nxt;
	end
	irq_reset_low_a: assert property ($rose(nrst) |-> !irq)
		else $error("irq high after reset");
	ctrl_top_zero_a: assert property (s_axi_rvalid && ra_r == pertb_pkg::IDX_CTRL
		|-> !s_axi_rdata[7]) else $error("control bit 7 read as one");
	flags_only_a: assert property (s_axi_rvalid && ra_r == pertb_pkg::IDX_FLAGS
		|-> s_axi_rdata inside {32'h0, 32'h2}) else $error("flag read bad");
	enables_only_a: assert property (s_axi_rvalid && ra_r == pertb_pkg::IDX_ENABLES
		|-> s_axi_rdata inside {32'h0, 32'h2}) else $error("enable read bad");
	unmapped_read_a: assert property (s_axi_rvalid && !(ra_r inside {10'h00c, 10'h011,
		10'h012, 10'h08c, 10'h092}) |-> s_axi_rresp == pertb_pkg::RESP_SLVERR
		&& s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	read_release_a: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid && s_axi_arready) else $error("read not released");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
	write_release_a: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not released");
endmodule
bind pertb_top pertb_monitor pertb_monitor_inst (.clock(clock), .nrst(nrst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

//--- pertb_pkg.sv
// Constants, types and register map of the period timer with scalers.
`default_nettype none
package pertb_pkg;

	// ----------------------------------------------------------------
	// Register indices; byte address is four times the index.
	// ----------------------------------------------------------------
	localparam logic [9:0] IDX_FLAGS = 10'h00c;
	localparam logic [9:0] IDX_COUNT = 10'h011;
	localparam logic [9:0] IDX_CTRL = 10'h012;
	localparam logic [9:0] IDX_ENABLES = 10'h08c;
	localparam logic [9:0] IDX_PERIOD = 10'h092;

	// ----------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------
	localparam int MATCH_BIT = 1;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'hff;
	localparam logic [7:0] FLAGS_RST = 8'h00;

	// ----------------------------------------------------------------
	// Prescale terminal counts and instruction clock division.
	// ----------------------------------------------------------------
	localparam logic [3:0] PRE_TC_1 = 4'h0;
	localparam logic [3:0] PRE_TC_4 = 4'h3;
	localparam logic [3:0] PRE_TC_16 = 4'hf;
	localparam int INSTR_DIV_DEF = 4;

	// ----------------------------------------------------------------
	// Bus responses.
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control register layout, bits 6..0.
	typedef struct packed {
		logic [3:0] postscale;
		logic run;
		logic [1:0] prescale;
	} pertb_ctrl_t;

	localparam pertb_ctrl_t CTRL_RST = 7'h00;

	typedef enum logic [1:0] {
		WS_IDLE = 2'b01,
		WS_RESP = 2'b10
	} pertb_wstate_t;

endpackage
`default_nettype wire

//--- pertb_top.sv
// Period timer with prescaler, postscaler and match interrupt behind AXI4-Lite.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module pertb_top #(
	parameter int INSTR_DIV = pertb_pkg::INSTR_DIV_DEF
) (
	input wire logic clock, // Core clock, 100 MHz.
	input wire logic nrst, // Asynchronous reset, active low.
	input wire logic [11:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [11:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	output logic irq // Level interrupt, high while an enabled flag is set.
);

	// ----------------------------------------------------------------
	// State declarations
	// ----------------------------------------------------------------
	pertb_pkg::pertb_wstate_t ws_r, ws_nxt;
	logic aw_have_r, aw_have_nxt;
	logic [9:0] aw_idx_r, aw_idx_nxt;
	logic w_have_r, w_have_nxt;
	logic [7:0] wbyte_r, wbyte_nxt;
	logic wlane_r, wlane_nxt;
	logic awready_r, awready_nxt;
	logic wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic arready_r, arready_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;

	pertb_pkg::pertb_ctrl_t ctrl_r, ctrl_nxt;
	logic [7:0] count_r, count_nxt;
	logic [7:0] period_r, period_nxt;
	logic [3:0] pre_cnt_r, pre_cnt_nxt;
	logic [3:0] post_cnt_r, post_cnt_nxt;
	logic [7:0] instr_cnt_r, instr_cnt_nxt;
	logic flag_r, flag_nxt;
	logic ie_r, ie_nxt;
	logic irq_r, irq_nxt;

	logic wr_fire;
	logic wr_ok;
	logic [9:0] ar_idx;
	logic [7:0] rd_byte;
	logic rd_ok;
	logic instr_tick;
	logic pre_tick;
	logic [3:0] pre_tc;
	logic match_set;

	// ----------------------------------------------------------------
	// Register write path
	// ----------------------------------------------------------------
	// A write is carried out once both address and data are held.
	assign wr_fire = (ws_r == pertb_pkg::WS_IDLE) && aw_have_r && w_have_r;

	always_comb
	begin
		wr_ok = 1'b0;
		if (aw_idx_r == pertb_pkg::IDX_FLAGS)
			wr_ok = 1'b1;
		else if (aw_idx_r == pertb_pkg::IDX_COUNT)
			wr_ok = 1'b1;
		else if (aw_idx_r == pertb_pkg::IDX_CTRL)
			wr_ok = 1'b1;
		else if (aw_idx_r == pertb_pkg::IDX_ENABLES)
			wr_ok = 1'b1;
		else if (aw_idx_r == pertb_pkg::IDX_PERIOD)
			wr_ok = 1'b1;
	end

	always_comb
	begin
		ws_nxt = ws_r;
		aw_have_nxt = aw_have_r;
		aw_idx_nxt = aw_idx_r;
		w_have_nxt = w_have_r;
		wbyte_nxt = wbyte_r;
		wlane_nxt = wlane_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		case (ws_r)
			pertb_pkg::WS_IDLE:
			begin
				if (s_axi_awvalid && awready_r)
				begin
					aw_have_nxt = 1'b1;
					aw_idx_nxt = s_axi_awaddr[11:2];
				end
				if (s_axi_wvalid && wready_r)
				begin
					w_have_nxt = 1'b1;
					wbyte_nxt = s_axi_wdata[7:0];
					wlane_nxt = s_axi_wstrb[0];
				end
				if (wr_fire)
				begin
					aw_have_nxt = 1'b0;
					w_have_nxt = 1'b0;
					bvalid_nxt = 1'b1;
					bresp_nxt = wr_ok ? pertb_pkg::RESP_OKAY : pertb_pkg::RESP_SLVERR;
					ws_nxt = pertb_pkg::WS_RESP;
				end
			end
			pertb_pkg::WS_RESP:
			begin
				if (s_axi_bready)
				begin
					bvalid_nxt = 1'b0;
					ws_nxt = pertb_pkg::WS_IDLE;
				end
			end
			default:
			begin
				ws_nxt = pertb_pkg::WS_IDLE;
			end
		endcase
		awready_nxt = (ws_nxt == pertb_pkg::WS_IDLE) && !aw_have_nxt;
		wready_nxt = (ws_nxt == pertb_pkg::WS_IDLE) && !w_have_nxt;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			ws_r <= pertb_pkg::WS_IDLE;
			aw_have_r <= 1'b0;
			aw_idx_r <= 10'h000;
			w_have_r <= 1'b0;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= pertb_pkg::RESP_OKAY;
		end
		else
		begin
			ws_r <= ws_nxt;
			aw_have_r <= aw_have_nxt;
			aw_idx_r <= aw_idx_nxt;
			w_have_r <= w_have_nxt;
			wbyte_r <= wbyte_nxt;
			wlane_r <= wlane_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Register read path
	// ----------------------------------------------------------------
	assign ar_idx = s_axi_araddr[11:2];

	always_comb
	begin
		rd_byte = 8'h00;
		rd_ok = 1'b1;
		if (ar_idx == pertb_pkg::IDX_FLAGS)
			rd_byte = 8'(flag_r) << pertb_pkg::MATCH_BIT;
		else if (ar_idx == pertb_pkg::IDX_COUNT)
			rd_byte = count_r;
		else if (ar_idx == pertb_pkg::IDX_CTRL)
			rd_byte = {1'b0, ctrl_r};
		else if (ar_idx == pertb_pkg::IDX_ENABLES)
			rd_byte = 8'(ie_r) << pertb_pkg::MATCH_BIT;
		else if (ar_idx == pertb_pkg::IDX_PERIOD)
			rd_byte = period_r;
		else
			rd_ok = 1'b0;
	end

	always_comb
	begin
		arready_nxt = arready_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && arready_r)
		begin
			arready_nxt = 1'b0;
			rvalid_nxt = 1'b1;
			rdata_nxt = {24'h000000, rd_byte};
			rresp_nxt = rd_ok ? pertb_pkg::RESP_OKAY : pertb_pkg::RESP_SLVERR;
		end
		else if (rvalid_r && s_axi_rready)
		begin
			rvalid_nxt = 1'b0;
			arready_nxt = 1'b1;
		end
		else if (!rvalid_r)
		begin
			arready_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= pertb_pkg::RESP_OKAY;
		end
		else
		begin
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Timer core
	// ----------------------------------------------------------------
	// The instruction clock runs at the core clock divided by INSTR_DIV.
	assign instr_tick = (instr_cnt_r == 8'(INSTR_DIV - 1));

	always_comb
	begin
		case (ctrl_r.prescale)
			2'b00: pre_tc = pertb_pkg::PRE_TC_1;
			2'b01: pre_tc = pertb_pkg::PRE_TC_4;
			default: pre_tc = pertb_pkg::PRE_TC_16;
		endcase
	end

	assign pre_tick = ctrl_r.run && instr_tick && (pre_cnt_r == pre_tc);

	always_comb
	begin
		instr_cnt_nxt = instr_tick ? 8'h00 : instr_cnt_r + 8'h01;
		ctrl_nxt = ctrl_r;
		count_nxt = count_r;
		period_nxt = period_r;
		pre_cnt_nxt = pre_cnt_r;
		post_cnt_nxt = post_cnt_r;
		ie_nxt = ie_r;
		match_set = 1'b0;
		if (ctrl_r.run && instr_tick)
			pre_cnt_nxt = pre_tick ? 4'h0 : pre_cnt_r + 4'h1;
		if (pre_tick)
		begin
			if (count_r == period_r)
			begin
				count_nxt = 8'h00;
				if (post_cnt_r == ctrl_r.postscale)
				begin
					post_cnt_nxt = 4'h0;
					match_set = 1'b1;
				end
				else
					post_cnt_nxt = post_cnt_r + 4'h1;
			end
			else
				count_nxt = count_r + 8'h01;
		end
		// A software load of the counter restarts both scalers.
		if (wr_fire && wlane_r)
		begin
			if (aw_idx_r == pertb_pkg::IDX_COUNT)
			begin
				count_nxt = wbyte_r;
				pre_cnt_nxt = 4'h0;
				post_cnt_nxt = 4'h0;
			end
			else if (aw_idx_r == pertb_pkg::IDX_CTRL)
				ctrl_nxt = wbyte_r[6:0];
			else if (aw_idx_r == pertb_pkg::IDX_PERIOD)
				period_nxt = wbyte_r;
			else if (aw_idx_r == pertb_pkg::IDX_ENABLES)
				ie_nxt = wbyte_r[pertb_pkg::MATCH_BIT];
		end
		// Writing a one clears the flag; a match in the same cycle wins.
		flag_nxt = flag_r;
		if (wr_fire && wlane_r && (aw_idx_r == pertb_pkg::IDX_FLAGS))
			flag_nxt = flag_r & ~wbyte_r[pertb_pkg::MATCH_BIT];
		flag_nxt = flag_nxt | match_set;
		irq_nxt = flag_nxt && ie_nxt;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_r <= pertb_pkg::CTRL_RST;
			count_r <= pertb_pkg::COUNT_RST;
			period_r <= pertb_pkg::PERIOD_RST;
			pre_cnt_r <= 4'h0;
			post_cnt_r <= 4'h0;
			instr_cnt_r <= 8'h00;
			flag_r <= pertb_pkg::FLAGS_RST[pertb_pkg::MATCH_BIT];
			ie_r <= 1'b0;
			irq_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			count_r <= count_nxt;
			period_r <= period_nxt;
			pre_cnt_r <= pre_cnt_nxt;
			post_cnt_r <= post_cnt_nxt;
			instr_cnt_r <= instr_cnt_nxt;
			flag_r <= flag_nxt;
			ie_r <= ie_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign irq = irq_r;

endmodule
`default_nettype wire

//--- pertb_top_tb.sv
// Self-checking testbench of the period timer.
`timescale 1ns/1ns
`default_nettype none
module pertb_top_tb;
	localparam int DIV = 1;
	logic clock, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	int err_count, checked, cyc, seed, t0, t1, p, q;
	pertb_top #(.INSTR_DIV(DIV)) pertb_top_inst (.clock(clock), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
	always #5 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;
	// --------
	// Bus tasks and checks.
	// --------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [9:0] i, input logic [7:0] v);
		@(posedge clock);
		awaddr <= {i, 2'b00};
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] i);
		@(posedge clock);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wait_irq(output int t);
		do
			@(posedge clock);
		while (irq !== 1'b1);
		t = cyc;
	endtask
	function automatic int per(int pp, int c, int qq);
		return (pp + 1) * (c == 0 ? 1 : (c == 1 ? 4 : 16)) * (qq + 1) * DIV;
	endfunction
	task automatic chk_reset;
		rd(pertb_pkg::IDX_COUNT);
		chk(d, 32'h00);
		rd(pertb_pkg::IDX_PERIOD);
		chk(d, 32'hff);
		rd(pertb_pkg::IDX_CTRL);
		chk(d, 32'h00);
		rd(pertb_pkg::IDX_FLAGS);
		chk(d, 32'h00);
		rd(pertb_pkg::IDX_ENABLES);
		chk(d, 32'h00);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge clock);
		err_count++;
		final_report();
	end
	// --------
	// Main sequence.
	// --------
	initial
	begin
		seed = 32'h8f205eaa;
		{clock, nrst, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{awaddr, araddr, wdata} = 56'h0;
		wstrb = 4'hf;
		{err_count, checked} = 64'h0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		chk_reset();
		wr(pertb_pkg::IDX_CTRL, 8'hfb);
		rd(pertb_pkg::IDX_CTRL);
		chk(d, 32'h7b);
		wr(10'h013, 8'h55);
		chk({30'h0, r}, 32'h2);
		rd(10'h013);
		chk({30'h0, r}, 32'h2);
		chk(d, 32'h0);
		for (int c = 0; c < 4; c++)
		begin
			p = 20 + ($random(seed) & 7);
			q = $random(seed) & 15;
			wr(pertb_pkg::IDX_CTRL, 8'h00);
			wr(pertb_pkg::IDX_PERIOD, p[7:0]);
			rd(pertb_pkg::IDX_PERIOD);
			chk(d, 32'(p));
			wr(pertb_pkg::IDX_COUNT, 8'h00);
			wr(pertb_pkg::IDX_FLAGS, 8'h02);
			wr(pertb_pkg::IDX_ENABLES, 8'h02);
			wr(pertb_pkg::IDX_CTRL, {1'b0, q[3:0], 1'b1, c[1:0]});
			wait_irq(t0);
			wr(pertb_pkg::IDX_FLAGS, 8'h02);
			rd(pertb_pkg::IDX_FLAGS);
			chk(d, 32'h0);
			chk({31'h0, irq}, 32'h0);
			wait_irq(t1);
			chk(32'(t1 - t0), 32'(per(p, c, q)));
			wr(pertb_pkg::IDX_ENABLES, 8'h00);
			rd(pertb_pkg::IDX_FLAGS);
			chk(d, 32'h2);
			chk({31'h0, irq}, 32'h0);
			wr(pertb_pkg::IDX_CTRL, {1'b0, q[3:0], 1'b0, c[1:0]});
			rd(pertb_pkg::IDX_COUNT);
			t0 = int'(d);
			repeat (40) @(posedge clock);
			rd(pertb_pkg::IDX_COUNT);
			chk(d, 32'(t0));
		end
		// A halted counter keeps a loaded value; a write without lane 0 leaves it alone.
		wr(pertb_pkg::IDX_COUNT, 8'h5a);
		chk({30'h0, r}, 32'h0);
		rd(pertb_pkg::IDX_COUNT);
		chk(d, 32'h5a);
		wstrb <= 4'he;
		wr(pertb_pkg::IDX_COUNT, 8'h33);
		wstrb <= 4'hf;
		rd(pertb_pkg::IDX_COUNT);
		chk(d, 32'h5a);
		// A reset in mid-run, with the timer running and the interrupt high.
		wr(pertb_pkg::IDX_COUNT, 8'h00);
		wr(pertb_pkg::IDX_PERIOD, 8'h05);
		wr(pertb_pkg::IDX_ENABLES, 8'h02);
		wr(pertb_pkg::IDX_CTRL, 8'h04);
		repeat (20) @(posedge clock);
		chk({31'h0, irq}, 32'h1);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		chk_reset();
		final_report();
	end
endmodule
`default_nettype wire
